// ===== hdl/lic_consts.svh
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH

// register indices; byte address is four times the index
`define LIC_IDX_HOOK_RING     8'h05
`define LIC_IDX_POWERDOWN     8'h06
`define LIC_IDX_SAMPLE_RATE   8'h07
`define LIC_IDX_RSVD_EIGHT    8'h08
`define LIC_IDX_RSVD_NINE     8'h09
`define LIC_IDX_LOOPBACK      8'h0a
`define LIC_IDX_IDENTITY      8'h0b
`define LIC_IDX_IRQ_STATUS    8'h20
`define LIC_IDX_IRQ_MASK      8'h21
`define LIC_IDX_SYS_CONTROL   8'h22

// hook_ring_control fields
`define LIC_BIT_RING_NEG      6
`define LIC_BIT_RING_POS      5
`define LIC_BIT_MONITOR       3
`define LIC_BIT_RING_IND      2
`define LIC_BIT_HOOK          0
// powerdown_control fields
`define LIC_BIT_LINE_PD       4
`define LIC_BIT_LOGIC_PD      3
// loopback_control field
`define LIC_BIT_LOOPBACK      0
// sys_control fields
`define LIC_BIT_WDOG_EN       0
`define LIC_BIT_SOFT_RESET    1
// interrupt bits
`define LIC_IRQ_RING_START    0
`define LIC_IRQ_RING_END      1
`define LIC_IRQ_WDOG          2
`define LIC_IRQ_W             3

// rate reset value and highest non-reserved rate code
`define LIC_RST_RATE          4'h1
`define LIC_RATE_MAX          4'h9

// timing
`define LIC_CLK_HZ            40000000
`define LIC_RING_HOLD_MS      5000
`define LIC_WDOG_MS           4096
`define LIC_RING_HOLD_CYC     (`LIC_RING_HOLD_MS * (`LIC_CLK_HZ / 1000))
`define LIC_WDOG_CYC          (`LIC_WDOG_MS * (`LIC_CLK_HZ / 1000))

`endif

// ===== hdl/lic_pkg.sv
package lic_pkg;
    typedef logic [7:0]  lic_byte_t;
    typedef logic [3:0]  lic_nib_t;
    typedef logic [27:0] lic_count_t;
endpackage

// ===== hdl/lic_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - bit 6 of hook_ring_control reads 1 while a negative ring is present
// - bit 5 of hook_ring_control reads 1 while a positive ring is present
// - bit 3 set enters low-power on-hook monitoring for caller-ID; clear returns
// - bit 2 shows ringing; clears five seconds after last positive ring or off-hook
// - writing 1 to bit 0 goes off-hook; writing 0 keeps or returns on-hook
// - bit 4 of powerdown_control powers down the line-side chip; 0 is normal
// - bit 3 powers down the logic; only a soft reset restores operation
// - bits 3:0 of sample_rate_select pick the rate; codes above 1001 reserved; reset 0001
// - software writes zeros to reserved bits; reads of them are undefined
// - loopback bit 0 routes transmit samples to receive after the filters, in place of rx_sample
// - identity register returns line-side identity 7:4 and system revision 3:0
// - enabled watchdog forces on-hook after 4.096 s without a register write
`include "lic_consts.svh"

module lic_regs
    import lic_pkg::*;
#(
    parameter int          SAMPLE_W      = 16,
    parameter int unsigned RING_HOLD_CYC = `LIC_RING_HOLD_CYC,
    parameter int unsigned WDOG_CYC      = `LIC_WDOG_CYC,
    parameter lic_nib_t    LINE_ID       = 4'h3, // arbitrary value
    parameter lic_nib_t    SYS_REV       = 4'h1  // arbitrary value
) (
    input  wire logic                pclk,              // bus clock, 40 MHz
    input  wire logic                presetn,           // async reset, active low
    input  wire logic                clk_en,            // freezes all state when low
    input  wire logic                psel,              // apb select
    input  wire logic                penable,           // apb access phase
    input  wire logic                pwrite,            // apb direction
    input  wire logic [9:0]          paddr,             // apb byte address
    input  wire logic [31:0]         pwdata,            // apb write data
    output logic      [31:0]         prdata,            // apb read data
    output logic                     pready,            // apb ready
    output logic                     pslverr,           // apb error, unmapped address
    input  wire logic                ring_pos_pin,      // positive ring detector, async
    input  wire logic                ring_neg_pin,      // negative ring detector, async
    input  wire logic [SAMPLE_W-1:0] tx_sample,         // transmit sample, same clock
    input  wire logic [SAMPLE_W-1:0] rx_sample,         // receive sample from filters
    output logic      [SAMPLE_W-1:0] rx_sample_out,     // receive sample to system
    output logic                     hook_control,      // line side off-hook
    output logic                     onhook_monitor_enable, // caller-id monitor
    output logic                     lineside_powerdown,    // line-side chip off
    output logic                     logic_powerdown,       // logic powered down
    output logic      [3:0]          sample_rate_code,      // selected rate
    output logic                     irq                    // level interrupt
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [9:0] a, input lic_byte_t idx);
        hit = (a[1:0] == 2'b00) && (a[9:2] == idx);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pos_sync_q;
    logic [1:0] neg_sync_q;
    logic       ring_pos_s;
    logic       ring_neg_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_sync_q <= 2'b00;
            neg_sync_q <= 2'b00;
        end else if (clk_en) begin
            pos_sync_q <= {pos_sync_q[0], ring_pos_pin};
            neg_sync_q <= {neg_sync_q[0], ring_neg_pin};
        end
    end

    assign ring_pos_s = pos_sync_q[1];
    assign ring_neg_s = neg_sync_q[1];

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup;
    logic wr_en;
    logic mapped;
    logic soft_reset;

    assign setup  = psel && !penable && !pready;
    // writes take effect at the completing edge of the access phase
    assign wr_en  = psel && penable && pready && pwrite && !pslverr;
    assign mapped = hit(paddr, `LIC_IDX_HOOK_RING)   || hit(paddr, `LIC_IDX_POWERDOWN)
                 || hit(paddr, `LIC_IDX_SAMPLE_RATE) || hit(paddr, `LIC_IDX_RSVD_EIGHT)
                 || hit(paddr, `LIC_IDX_RSVD_NINE)   || hit(paddr, `LIC_IDX_LOOPBACK)
                 || hit(paddr, `LIC_IDX_IDENTITY)    || hit(paddr, `LIC_IDX_IRQ_STATUS)
                 || hit(paddr, `LIC_IDX_IRQ_MASK)    || hit(paddr, `LIC_IDX_SYS_CONTROL);
    assign soft_reset = wr_en && hit(paddr, `LIC_IDX_SYS_CONTROL)
                     && pwdata[`LIC_BIT_SOFT_RESET];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic     hook_q;
    logic     monitor_q;
    logic     line_pd_q;
    logic     logic_pd_q;
    lic_nib_t rate_q;
    logic     loop_q;
    logic     wdog_en_q;
    logic     wdog_fire;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hook_q    <= 1'b0;
            monitor_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset) begin
                hook_q    <= 1'b0;
                monitor_q <= 1'b0;
            end else if (wr_en && hit(paddr, `LIC_IDX_HOOK_RING)) begin
                hook_q    <= pwdata[`LIC_BIT_HOOK];
                monitor_q <= pwdata[`LIC_BIT_MONITOR];
            end else if (wdog_fire) begin
                hook_q    <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_pd_q  <= 1'b0;
            logic_pd_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset) begin
                line_pd_q  <= 1'b0;
                logic_pd_q <= 1'b0;
            end else if (wr_en && hit(paddr, `LIC_IDX_POWERDOWN)) begin
                // clock generator must already be set up when this clears
                line_pd_q  <= pwdata[`LIC_BIT_LINE_PD];
                // a written zero does not wake the logic
                logic_pd_q <= logic_pd_q | pwdata[`LIC_BIT_LOGIC_PD];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= `LIC_RST_RATE;
            loop_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset) begin
                rate_q <= `LIC_RST_RATE;
                loop_q <= 1'b0;
            end else if (wr_en && hit(paddr, `LIC_IDX_SAMPLE_RATE)) begin
                rate_q <= pwdata[3:0];
            end else if (wr_en && hit(paddr, `LIC_IDX_LOOPBACK)) begin
                loop_q <= pwdata[`LIC_BIT_LOOPBACK];
            end
        end
    end

    // the watchdog enable sticks until a hardware reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_en_q <= 1'b0;
        end else if (clk_en && wr_en && hit(paddr, `LIC_IDX_SYS_CONTROL)) begin
            wdog_en_q <= wdog_en_q | pwdata[`LIC_BIT_WDOG_EN];
        end
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    lic_count_t wdog_cnt_q;

    assign wdog_fire = wdog_en_q && !wr_en && (wdog_cnt_q == lic_count_t'(WDOG_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_q <= '0;
        end else if (clk_en) begin
            if (!wdog_en_q || wr_en || wdog_fire) begin
                wdog_cnt_q <= '0;
            end else begin
                wdog_cnt_q <= wdog_cnt_q + lic_count_t'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // ring indication
    // ------------------------------------------------------------
    logic       ring_ind_q;
    logic       ring_any_q;
    logic       off_hook_cmd;
    logic       ring_timeout;
    lic_count_t ring_cnt_q;

    assign off_hook_cmd = wr_en && hit(paddr, `LIC_IDX_HOOK_RING)
                       && pwdata[`LIC_BIT_HOOK] && !hook_q;
    assign ring_timeout = ring_ind_q && !ring_pos_s
                       && (ring_cnt_q == lic_count_t'(RING_HOLD_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_cnt_q <= '0;
        end else if (clk_en) begin
            if (ring_pos_s || !ring_ind_q || ring_timeout) begin
                ring_cnt_q <= '0;
            end else begin
                ring_cnt_q <= ring_cnt_q + lic_count_t'(1);
            end
        end
    end

    // going off-hook clears the indication; a ring still present sets it again on the next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_ind_q <= 1'b0;
            ring_any_q <= 1'b0;
        end else if (clk_en) begin
            ring_any_q <= ring_pos_s | ring_neg_s;
            if (off_hook_cmd || soft_reset || ring_timeout) begin
                ring_ind_q <= 1'b0;
            end else if (ring_pos_s || ring_neg_s) begin
                ring_ind_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [`LIC_IRQ_W-1:0] irq_st_q;
    logic [`LIC_IRQ_W-1:0] irq_mask_q;
    logic [`LIC_IRQ_W-1:0] irq_ev;
    logic [`LIC_IRQ_W-1:0] irq_clr;

    assign irq_ev = {wdog_fire, ring_timeout, (ring_pos_s | ring_neg_s) & ~ring_any_q};
    assign irq_clr = (wr_en && hit(paddr, `LIC_IDX_IRQ_STATUS))
                   ? pwdata[`LIC_IRQ_W-1:0] : '0;

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= '0;
        end else if (clk_en) begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (clk_en && wr_en && hit(paddr, `LIC_IDX_IRQ_MASK)) begin
            irq_mask_q <= pwdata[`LIC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    lic_byte_t rd_byte;

    // reserved bits and both reserved registers read zero; ring detector and
    // identity bits have no write path; interrupt status bits clear on a written 1
    always_comb begin
        rd_byte = '0;
        if (hit(paddr, `LIC_IDX_HOOK_RING)) begin
            rd_byte[`LIC_BIT_RING_NEG] = ring_neg_s;
            rd_byte[`LIC_BIT_RING_POS] = ring_pos_s;
            rd_byte[`LIC_BIT_MONITOR]  = monitor_q;
            rd_byte[`LIC_BIT_RING_IND] = ring_ind_q;
            rd_byte[`LIC_BIT_HOOK]     = hook_q;
        end else if (hit(paddr, `LIC_IDX_POWERDOWN)) begin
            rd_byte[`LIC_BIT_LINE_PD]  = line_pd_q;
            rd_byte[`LIC_BIT_LOGIC_PD] = logic_pd_q;
        end else if (hit(paddr, `LIC_IDX_SAMPLE_RATE)) begin
            rd_byte[3:0] = rate_q;
        end else if (hit(paddr, `LIC_IDX_LOOPBACK)) begin
            rd_byte[`LIC_BIT_LOOPBACK] = loop_q;
        end else if (hit(paddr, `LIC_IDX_IDENTITY)) begin
            rd_byte = {LINE_ID, SYS_REV};
        end else if (hit(paddr, `LIC_IDX_IRQ_STATUS)) begin
            rd_byte[`LIC_IRQ_W-1:0] = irq_st_q;
        end else if (hit(paddr, `LIC_IDX_IRQ_MASK)) begin
            rd_byte[`LIC_IRQ_W-1:0] = irq_mask_q;
        end else if (hit(paddr, `LIC_IDX_SYS_CONTROL)) begin
            rd_byte[`LIC_BIT_WDOG_EN] = wdog_en_q;
        end
    end

    // answer is prepared in the setup cycle, so every access has no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // line-side control and data path
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hook_control          <= 1'b0;
            onhook_monitor_enable <= 1'b0;
            lineside_powerdown    <= 1'b0;
            logic_powerdown       <= 1'b0;
            sample_rate_code      <= `LIC_RST_RATE;
        end else if (clk_en) begin
            hook_control          <= hook_q;
            onhook_monitor_enable <= monitor_q && !hook_q;
            lineside_powerdown    <= line_pd_q;
            logic_powerdown       <= logic_pd_q;
            sample_rate_code      <= rate_q;
        end
    end

    // samples stop moving while the logic is powered down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sample_out <= '0;
        end else if (clk_en && !logic_pd_q) begin
            rx_sample_out <= loop_q ? tx_sample : rx_sample;
        end
    end

endmodule

// ===== verification/lic_line_model.sv
`timescale 1ns/100ps
module lic_line_model (
    input  wire logic        pclk,         // bus clock
    input  wire logic        presetn,      // reset, active low
    input  wire logic        pos_on,       // line carries positive ring
    input  wire logic        neg_on,       // line carries negative ring
    output logic             ring_pos_pin, // positive detector
    output logic             ring_neg_pin, // negative detector
    output logic      [15:0] rx_sample     // filtered receive stream
);
    // detectors lag the line by a cycle, as a comparator would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_pos_pin <= 1'b0;
            ring_neg_pin <= 1'b0;
        end else begin
            ring_pos_pin <= pos_on;
            ring_neg_pin <= neg_on;
        end
    end
    // stream changes every cycle so a stuck receive path cannot pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sample <= 16'h0000;
        end else begin
            rx_sample <= {rx_sample[14:0], ~rx_sample[15]} + 16'h0101;
        end
    end
endmodule

// ===== verification/lic_regs_checker.sv
`timescale 1ns/100ps
module lic_regs_checker #(
    parameter int SAMPLE_W = 16
) (
    input wire logic                pclk,                  // clock
    input wire logic                presetn,               // reset
    input wire logic                clk_en,                // enable
    input wire logic                psel,                  // apb
    input wire logic                penable,               // apb
    input wire logic                pwrite,                // apb
    input wire logic [9:0]          paddr,                 // apb
    input wire logic [31:0]         pwdata,                // apb
    input wire logic [31:0]         prdata,                // apb
    input wire logic                pready,                // apb
    input wire logic                pslverr,               // apb
    input wire logic [SAMPLE_W-1:0] tx_sample,             // sample
    input wire logic [SAMPLE_W-1:0] rx_sample,             // sample
    input wire logic [SAMPLE_W-1:0] rx_sample_out,         // sample
    input wire logic                hook_control,          // line
    input wire logic                onhook_monitor_enable, // line
    input wire logic                logic_powerdown,       // line
    input wire logic [3:0]          sample_rate_code       // rate
);
    logic       setup;
    logic       wr_hook;
    logic [3:0] wr_rate;
    logic       soft_rst;
    assign setup   = psel && !penable && clk_en;
    assign soft_rst = psel && penable && pready && pwrite && paddr == 10'h088 && pwdata[1];
    assign wr_hook = pwdata[0];
    assign wr_rate = pwdata[3:0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // bus and register behaviour
    // ----------------------------------------
    a_ready_after_setup: assert property (
        setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error without ready");
    a_misaligned_refused: assert property (
        setup && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned access accepted");
    a_read_upper_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_hook_follows_write: assert property (
        setup && pwrite && paddr == 10'h014 |-> ##3 hook_control == $past(wr_hook, 3))
        else $error("hook output does not follow write");
    a_rate_follows_write: assert property (
        setup && pwrite && paddr == 10'h01c |-> ##3 sample_rate_code == $past(wr_rate, 3))
        else $error("rate output does not follow write");
    a_monitor_when_onhook: assert property (
        onhook_monitor_enable |-> !hook_control)
        else $error("monitor active while off-hook");
    a_logic_down_sticky: assert property (
        logic_powerdown && !soft_rst && !$past(soft_rst) |=> logic_powerdown)
        else $error("logic powerdown left without soft reset");
    a_rx_path_source: assert property (
        $past(presetn, 2) && $past(presetn) && $past(clk_en) && !$past(logic_powerdown)
        && !logic_powerdown
        |-> rx_sample_out == $past(tx_sample) || rx_sample_out == $past(rx_sample))
        else $error("receive output from neither source");
    c_refused: cover property (pslverr);
    c_offhook: cover property ($rose(hook_control));
    c_logic_down: cover property (logic_powerdown);
endmodule

bind lic_regs lic_regs_checker #(.SAMPLE_W(SAMPLE_W)) lic_regs_checker_i (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_sample, .rx_sample, .rx_sample_out, .hook_control, .onhook_monitor_enable,
    .logic_powerdown, .sample_rate_code
);

// ===== verification/lic_regs_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin \
        check_count++; \
        if ((got) !== (ex)) begin \
            num_errors++; \
            $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
        end \
    end

module lic_regs_tb;
    import lic_pkg::*;
    localparam int       HOLD = 50;
    localparam int       WDOG = 40;
    localparam lic_nib_t LID  = 4'h5; // arbitrary value
    localparam lic_nib_t REV  = 4'h2; // arbitrary value
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, clk_en;
    logic        pos_on, neg_on, ring_pos_pin, ring_neg_pin;
    logic        hook_control, onhook_monitor_enable, lineside_powerdown, logic_powerdown;
    logic [9:0]  paddr;
    logic [3:0]  sample_rate_code;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] tx_sample, rx_sample, rx_sample_out, exp_s;
    int          num_errors, check_count, cycles;
    int          mdl[int];

    lic_regs #(.RING_HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .LINE_ID(LID), .SYS_REV(REV)) lic_regs_i (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ring_pos_pin, .ring_neg_pin, .tx_sample, .rx_sample,
        .rx_sample_out, .hook_control, .onhook_monitor_enable, .lineside_powerdown,
        .logic_powerdown, .sample_rate_code, .irq
    );
    lic_line_model lic_line_model_i (
        .pclk, .presetn, .pos_on, .neg_on, .ring_pos_pin, .ring_neg_pin, .rx_sample
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // a hang anywhere ends the run as a failure
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       input logic [1:0] lo);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, lo};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // model keeps only the writable bits; logic powerdown ignores a written 0
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 2'b00);
        case (idx)
            8'h05: mdl[5] = d & 32'h0000_0009;
            8'h06: mdl[6] = (d & 32'h0000_0018) | (mdl[6] & 32'h0000_0008);
            8'h07: mdl[7] = d & 32'h0000_000f;
            8'h0a: mdl[10] = d & 32'h0000_0001;
            default: ;
        endcase
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] extra);
        apb(1'b0, idx, 32'h0000_0000, 2'b00);
        `CHK("read data", 32'(mdl[idx]) | {24'h00_0000, extra}, rd)
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, pos_on, neg_on, presetn} = 6'b00_0000;
        clk_en = 1'b1;
        {paddr, pwdata, tx_sample} = '0;
        seed = 32'he261_c698;
        mdl = '{5: 0, 6: 0, 7: 1, 8: 0, 9: 0, 10: 0, 11: {LID, REV}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 5; i < 12; i++) rd_chk(8'(i), 8'h00);
        for (int c = 15; c >= 0; c--) begin
            wr(8'h07, 32'(c));
            repeat (2) @(posedge pclk);
            `CHK("rate", 4'(c), sample_rate_code)
        end
        wr(8'h0b, 32'h0000_00ff);
        rd_chk(8'h0b, 8'h00);
        wr(8'h08, 32'h0000_0000);
        rd_chk(8'h08, 8'h00);
        wr(8'h05, 32'h0000_006d);
        repeat (2) @(posedge pclk);
        `CHK("hook monitor", 2'b10, {hook_control, onhook_monitor_enable})
        rd_chk(8'h05, 8'h00);
        wr(8'h05, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        `CHK("hook monitor", 2'b01, {hook_control, onhook_monitor_enable})
        wr(8'h05, 32'h0000_0000);
        wr(8'h21, 32'h0000_0001);
        pos_on <= 1'b1;
        neg_on <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        rd_chk(8'h05, 8'h64);
        wr(8'h20, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        pos_on <= 1'b0;
        neg_on <= 1'b0;
        repeat (HOLD - 10) @(posedge pclk);
        rd_chk(8'h05, 8'h04);
        repeat (20) @(posedge pclk);
        rd_chk(8'h05, 8'h00);
        `CHK("masked irq", 1'b0, irq)
        pos_on <= 1'b1;
        repeat (6) @(posedge pclk);
        pos_on <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_chk(8'h05, 8'h04);
        wr(8'h05, 32'h0000_0001);
        rd_chk(8'h05, 8'h00);
        wr(8'h06, 32'h0000_0018);
        repeat (2) @(posedge pclk);
        `CHK("powerdown", 2'b11, {lineside_powerdown, logic_powerdown})
        wr(8'h07, 32'h0000_0003); // clock set up before the line side wakes
        wr(8'h06, 32'h0000_0000);
        rd_chk(8'h06, 8'h00);
        wr(8'h22, 32'h0000_0002);
        mdl = '{5: 0, 6: 0, 7: 1, 8: 0, 9: 0, 10: 0, 11: {LID, REV}};
        repeat (2) @(posedge pclk);
        `CHK("powerdown", 3'b000, {lineside_powerdown, logic_powerdown, hook_control})
        rd_chk(8'h07, 8'h00);
        for (int lb = 1; lb >= 0; lb--) begin
            wr(8'h0a, 32'(lb));
            repeat (4) begin
                tx_sample <= 16'(rnd());
                @(posedge pclk);
                exp_s = (lb == 1) ? tx_sample : rx_sample;
                @(posedge pclk);
                `CHK("rx out", exp_s, rx_sample_out)
            end
        end
        // with the enable low the receive output must hold its last sample
        clk_en <= 1'b0;
        @(posedge pclk);
        exp_s = rx_sample_out;
        repeat (4) @(posedge pclk);
        `CHK("frozen rx out", exp_s, rx_sample_out)
        clk_en <= 1'b1;
        apb(1'b0, 8'hff, 32'h0000_0000, 2'b00);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        apb(1'b1, 8'h05, 32'h0000_0001, 2'b01);
        repeat (2) @(posedge pclk);
        `CHK("misaligned", 2'b10, {err, hook_control})
        wr(8'h20, 32'h0000_0007);
        wr(8'h21, 32'h0000_0004);
        wr(8'h22, 32'h0000_0001);
        wr(8'h05, 32'h0000_0001);
        repeat (WDOG + 5) @(posedge pclk);
        `CHK("watchdog", 2'b01, {hook_control, irq})
        wr(8'h20, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        close_out();
    end
endmodule
